/* File: logic/dcir_router.v */
/*
  Top of the digital I/O interrupt router: four port groups, the
  three-counter unit and the single host interrupt request.
  Assumes an 8-bit register window decoded from the host bridge, one
  200 MHz clock, and pins that are synchronous to it.
*/
`timescale 1ns/10ps
`include "dcir_consts.vh"

// How it works
// - host interrupt only passes while the master enable is set.
// - counters raise interrupts only while the counter enable is set.
// - select high takes the second counter, cascaded behind the first.
// - select low takes the first counter alone; the third never interrupts.
// - first counter runs from a 2 MHz tick, crystal over 8, always gated on.
// - second counter counts the first counter's wraps, always gated on.
// - three 16-bit counters, the second cascaded on the first; only the first two feed interrupts.
// - exactly one of the first two counters can be the counter source.
// - in handshake modes port C bits 0 and 3 become interrupt sources.
// - each of the eight port sources has its own enable bit.
// - reset places every port of every group in input mode.
// - groups offer 8+8+4+4, three 8-bit, or 8+8 with handshake.
// - combined request drives the active-low host interrupt line.
// - enable byte holds two bits per group, odd bit B, even bit A.
module dcir_router #(
  parameter                       TICK_DIV = `DCIR_TICK_CYC
) (
  input  wire                     ref_clk,
  input  wire                     resetn,
  input  wire [4:0]               ioAddr,
  input  wire [7:0]               ioWrData,
  input  wire                     ioWrStb,
  input  wire                     ioRdStb,
  output reg  [7:0]               ioRdData,
  input  wire [95:0]              pinIn,
  output wire [95:0]              pinOut,
  output wire [95:0]              pinOe,
  output reg                      hostIrqN
);

  // ==========================================================
  // helpers
  function [23:0] drive_mask;
    input [7:0] cfg;
    begin
      drive_mask = {{4{~cfg[`DCIR_GCFG_CU_IN]}},
                    {4{~cfg[`DCIR_GCFG_CL_IN]}},
                    {8{~cfg[`DCIR_GCFG_B_IN]}},
                    {8{~cfg[`DCIR_GCFG_A_IN]}}};
      // handshake lines stay inputs so they can act as requests
      if (handshake(cfg)) begin
        drive_mask[16 + `DCIR_C_IRQ_A_BIT] = 1'b0;
        drive_mask[16 + `DCIR_C_IRQ_B_BIT] = 1'b0;
      end
    end
  endfunction

  function handshake;
    input [7:0] cfg;
    begin
      handshake = cfg[`DCIR_GCFG_AMODE_HI] | cfg[`DCIR_GCFG_AMODE_LO] |
                  cfg[`DCIR_GCFG_BMODE];
    end
  endfunction

  function [7:0] merge_port;
    input [7:0] latch;
    input [7:0] pins;
    input [7:0] drive;
    begin
      merge_port = (latch & drive) | (pins & ~drive);
    end
  endfunction

  // ==========================================================
  // state
  reg  [7:0]                      grpCfg [0:3];
  reg  [7:0]                      grpLatA [0:3];
  reg  [7:0]                      grpLatB [0:3];
  reg  [7:0]                      grpLatC [0:3];
  reg  [95:0]                     pinOutReg;
  reg  [95:0]                     pinOeReg;
  reg  [7:0]                      portIrqEnable;
  reg                             irqMasterEnable;
  reg                             counterIrqEnable;
  reg                             counterSourceSelect;
  reg  [7:0]                      next_rdData;

  wire                            groupHit;
  wire [1:0]                      grpIdx;
  wire [1:0]                      grpSel;
  wire                            tick;
  wire [7:0]                      ctrRdData [0:2];
  wire [2:0]                      ctrOut;
  wire [2:0]                      ctrWrap;
  wire [2:0]                      ctrWrStb;
  wire [2:0]                      ctrRdStb;
  wire [2:0]                      ctrArm;
  wire [2:0]                      ctrEn;
  wire [7:0]                      portIrqRaw;
  wire                            portEvent;
  wire                            counterEvent;
  wire [1:0]                      ctrCfgSel;
  wire [23:0]                     selDrive;
  wire [7:0]                      selDriveA;
  wire [7:0]                      selDriveB;
  wire [7:0]                      selDriveC;
  wire                            irqSrcWr;
  wire                            irqCtlWr;
  wire                            ctrSrcActive;
  wire [7:0]                      ctlByte;

  assign groupHit  = ~ioAddr[4];
  assign grpIdx    = ioAddr[3:2];
  assign grpSel    = ioAddr[1:0];
  assign ctrCfgSel = ioWrData[`DCIR_CTR_SEL_HI:`DCIR_CTR_SEL_LO];
  assign pinOut    = pinOutReg;
  assign pinOe     = pinOeReg;
  assign irqSrcWr  = ioWrStb && (ioAddr == `DCIR_OFF_IRQ_SRC);
  assign irqCtlWr  = ioWrStb && (ioAddr == `DCIR_OFF_IRQ_CTL);

  // direction of the addressed group, split per port
  assign selDrive  = drive_mask(grpCfg[grpIdx]);
  assign selDriveA = selDrive[7:0];
  assign selDriveB = selDrive[15:8];
  assign selDriveC = selDrive[23:16];

  // ==========================================================
  // port groups
  integer g;
  integer p;

  always @(posedge ref_clk) begin
    if (!resetn) begin
      for (g = 0; g < 4; g = g + 1) begin
        grpCfg[g]  <= `DCIR_GCFG_RESET;
        grpLatA[g] <= 8'h00;
        grpLatB[g] <= 8'h00;
        grpLatC[g] <= 8'h00;
      end
    end else if (ioWrStb && groupHit) begin
      case (grpSel)
        `DCIR_SEL_PORT_A: grpLatA[grpIdx] <= ioWrData;
        `DCIR_SEL_PORT_B: grpLatB[grpIdx] <= ioWrData;
        `DCIR_SEL_PORT_C: grpLatC[grpIdx] <= ioWrData;
        default: begin
          if (ioWrData[`DCIR_GCFG_SET]) begin
            // mode set picks one of the three arrangements
            grpCfg[grpIdx]  <= ioWrData;
            grpLatA[grpIdx] <= 8'h00;
            grpLatB[grpIdx] <= 8'h00;
            grpLatC[grpIdx] <= 8'h00;
          end else begin
            // single port C bit set or reset
            grpLatC[grpIdx][ioWrData[3:1]] <= ioWrData[0];
          end
        end
      endcase
    end
  end

  // pin drivers registered so the outputs come from flops
  always @(posedge ref_clk) begin
    if (!resetn) begin
      pinOutReg <= 96'h0;
      pinOeReg  <= 96'h0;
    end else begin
      for (p = 0; p < 4; p = p + 1) begin
        pinOutReg[p*24 +: 24] <= {grpLatC[p], grpLatB[p], grpLatA[p]};
        pinOeReg[p*24 +: 24]  <= drive_mask(grpCfg[p]);
      end
    end
  end

  // handshake request lines, even bit A, odd bit B per group
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : irqTap
      assign portIrqRaw[2*k]   = handshake(grpCfg[k]) &
                                 pinIn[k*24 + 16 + `DCIR_C_IRQ_A_BIT];
      assign portIrqRaw[2*k+1] = handshake(grpCfg[k]) &
                                 pinIn[k*24 + 16 + `DCIR_C_IRQ_B_BIT];
    end
  endgenerate

  assign portEvent = |(portIrqRaw & portIrqEnable);

  // ==========================================================
  // counter unit
  assign ctrEn[0] = tick;
  assign ctrEn[1] = ctrWrap[0];
  assign ctrEn[2] = tick;

  generate
    for (k = 0; k < `DCIR_CTR_COUNT; k = k + 1) begin : ctr
      // window offset and arm index of this counter
      localparam integer CTR_OFF = `DCIR_OFF_COUNTER_SOURCE_SELECT + k;
      localparam integer CTR_IDX = k;
      assign ctrWrStb[k] = ioWrStb && (ioAddr == CTR_OFF[4:0]);
      assign ctrRdStb[k] = ioRdStb && (ioAddr == CTR_OFF[4:0]);
      assign ctrArm[k]   = ioWrStb && (ioAddr == `DCIR_OFF_CTR_CFG) &&
                           (ctrCfgSel == CTR_IDX[1:0]);

      dcir_counter uCounter (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .countEn   (ctrEn[k]),
        .armStb    (ctrArm[k]),
        .wrStb     (ctrWrStb[k]),
        .wrData    (ioWrData),
        .rdStb     (ctrRdStb[k]),
        .rdData    (ctrRdData[k]),
        .outLevel  (ctrOut[k]),
        .wrapPulse (ctrWrap[k])
      );
    end
  endgenerate

  dcir_tick_div #(.DIV(TICK_DIV)) uTickDiv (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .tick    (tick)
  );

  // one source only; the third counter is not looked at
  assign ctrSrcActive = counterSourceSelect ? ~ctrOut[1] : ~ctrOut[0];
  assign counterEvent = counterIrqEnable & ctrSrcActive;

  // control byte as read back, upper bits zero
  assign ctlByte = {5'h00, irqMasterEnable, counterIrqEnable, counterSourceSelect} &
                   `DCIR_CTL_MASK;

  // ==========================================================
  // interrupt control registers
  always @(posedge ref_clk) begin
    if (!resetn) begin
      portIrqEnable       <= 8'h00;
      irqMasterEnable     <= 1'b0;
      counterIrqEnable    <= 1'b0;
      counterSourceSelect <= 1'b0;
    end else begin
      if (irqSrcWr)
        portIrqEnable <= ioWrData;
      if (irqCtlWr) begin
        irqMasterEnable     <= ioWrData[`DCIR_CTL_MASTER];
        counterIrqEnable    <= ioWrData[`DCIR_CTL_CTR_EN];
        counterSourceSelect <= ioWrData[`DCIR_CTL_CTR_SEL];
      end
    end
  end

  // host request, active low
  always @(posedge ref_clk) begin
    if (!resetn)
      hostIrqN <= 1'b1;
    else
      hostIrqN <= ~(irqMasterEnable & (portEvent | counterEvent));
  end

  // ==========================================================
  // readback
  always @* begin
    next_rdData = 8'h00;
    if (groupHit) begin
      case (grpSel)
        `DCIR_SEL_PORT_A:
          next_rdData = merge_port(grpLatA[grpIdx], pinIn[grpIdx*24 +: 8],
                                   selDriveA);
        `DCIR_SEL_PORT_B:
          next_rdData = merge_port(grpLatB[grpIdx], pinIn[grpIdx*24 + 8 +: 8],
                                   selDriveB);
        `DCIR_SEL_PORT_C:
          next_rdData = merge_port(grpLatC[grpIdx], pinIn[grpIdx*24 + 16 +: 8],
                                   selDriveC);
        default:
          next_rdData = grpCfg[grpIdx];
      endcase
    end else begin
      case (ioAddr)
        `DCIR_OFF_COUNTER_SOURCE_SELECT:    next_rdData = ctrRdData[0];
        `DCIR_OFF_CTR2:    next_rdData = ctrRdData[1];
        `DCIR_OFF_CTR3:    next_rdData = ctrRdData[2];
        `DCIR_OFF_IRQ_SRC: next_rdData = portIrqEnable;
        `DCIR_OFF_IRQ_CTL: next_rdData = ctlByte;
        default:           next_rdData = 8'h00;
      endcase
    end
  end

  always @(posedge ref_clk) begin
    if (!resetn)
      ioRdData <= 8'h00;
    else if (ioRdStb)
      ioRdData <= next_rdData;
  end

endmodule

/* File: pkg/dcir_consts.vh */
/*
  Constants for the digital I/O interrupt router: register offsets,
  field positions, reset values and the counter tick rate.
  Assumes it is included by bare name from files under logic/.
*/
`ifndef DCIR_CONSTS_VH
`define DCIR_CONSTS_VH

// ==========================================================
// clocking
`define DCIR_REF_HZ        200000000
`define DCIR_XTAL_HZ       16000000
`define DCIR_XTAL_DIV      8
`define DCIR_CTR_SRC_HZ    (`DCIR_XTAL_HZ / `DCIR_XTAL_DIV)
`define DCIR_TICK_CYC      (`DCIR_REF_HZ / `DCIR_CTR_SRC_HZ)
`define DCIR_TICK_BITS     8

// ==========================================================
// register window offsets
`define DCIR_OFF_COUNTER_SOURCE_SELECT      5'h10
`define DCIR_OFF_CTR2      5'h11
`define DCIR_OFF_CTR3      5'h12
`define DCIR_OFF_CTR_CFG   5'h13
`define DCIR_OFF_IRQ_SRC   5'h14
`define DCIR_OFF_IRQ_CTL   5'h15
`define DCIR_SEL_PORT_A    2'h0
`define DCIR_SEL_PORT_B    2'h1
`define DCIR_SEL_PORT_C    2'h2
`define DCIR_SEL_CFG       2'h3

// ==========================================================
// counter interrupt control fields
`define DCIR_CTL_MASTER    2
`define DCIR_CTL_CTR_EN    1
`define DCIR_CTL_CTR_SEL   0
`define DCIR_CTL_MASK      8'h07

// ==========================================================
// group configuration fields
`define DCIR_GCFG_RESET    8'h9B
`define DCIR_GCFG_SET      7
`define DCIR_GCFG_AMODE_HI 6
`define DCIR_GCFG_AMODE_LO 5
`define DCIR_GCFG_A_IN     4
`define DCIR_GCFG_CU_IN    3
`define DCIR_GCFG_BMODE    2
`define DCIR_GCFG_B_IN     1
`define DCIR_GCFG_CL_IN    0
`define DCIR_C_IRQ_A_BIT   3
`define DCIR_C_IRQ_B_BIT   0

// ==========================================================
// counter unit
`define DCIR_CTR_BITS      16
`define DCIR_CTR_COUNT     3
`define DCIR_CTR_SEL_HI    7
`define DCIR_CTR_SEL_LO    6

`endif

/* File: logic/dcir_tick_div.v */
/*
  Divider that turns ref_clk into the one-cycle enable that stands in
  for the crystal-derived counter source.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
`include "dcir_consts.vh"

module dcir_tick_div #(
  parameter                       DIV = `DCIR_TICK_CYC
) (
  input  wire                     ref_clk,
  input  wire                     resetn,
  output reg                      tick
);

  reg [`DCIR_TICK_BITS-1:0]       divCount;

  // ==========================================================
  // modulo counter
  always @(posedge ref_clk) begin
    if (!resetn) begin
      divCount <= {`DCIR_TICK_BITS{1'b0}};
      tick     <= 1'b0;
    end else if (divCount == DIV[`DCIR_TICK_BITS-1:0] - 8'h01) begin
      divCount <= {`DCIR_TICK_BITS{1'b0}};
      tick     <= 1'b1;
    end else begin
      divCount <= divCount + 8'h01;
      tick     <= 1'b0;
    end
  end

endmodule

/* File: logic/dcir_counter.v */
/*
  One 16-bit down counter with byte-wide load and readback.
  Assumes the count enable is a one-cycle pulse in ref_clk.
*/
`timescale 1ns/10ps
`include "dcir_consts.vh"

module dcir_counter (
  input  wire                     ref_clk,
  input  wire                     resetn,
  input  wire                     countEn,
  input  wire                     armStb,
  input  wire                     wrStb,
  input  wire [7:0]               wrData,
  input  wire                     rdStb,
  output wire [7:0]               rdData,
  output reg                      outLevel,
  output reg                      wrapPulse
);

  reg [`DCIR_CTR_BITS-1:0]        count;
  reg [`DCIR_CTR_BITS-1:0]        reload;
  reg [7:0]                       lowByte;
  reg                             wrHigh;
  reg                             rdHigh;
  reg                             running;

  assign rdData = rdHigh ? count[15:8] : count[7:0];

  // ==========================================================
  // load, count and terminal output
  always @(posedge ref_clk) begin
    if (!resetn) begin
      count     <= 16'h0000;
      reload    <= 16'h0000;
      lowByte   <= 8'h00;
      wrHigh    <= 1'b0;
      rdHigh    <= 1'b0;
      running   <= 1'b0;
      outLevel  <= 1'b1;
      wrapPulse <= 1'b0;
    end else begin
      wrapPulse <= 1'b0;
      if (rdStb)
        rdHigh <= ~rdHigh;
      if (armStb) begin
        running  <= 1'b0;
        wrHigh   <= 1'b0;
        rdHigh   <= 1'b0;
        outLevel <= 1'b1;
      end else if (wrStb) begin
        // low byte first, high byte completes the load
        if (!wrHigh) begin
          lowByte <= wrData;
          wrHigh  <= 1'b1;
        end else begin
          reload  <= {wrData, lowByte};
          count   <= {wrData, lowByte};
          wrHigh  <= 1'b0;
          running <= 1'b1;
        end
      end else if (countEn && running) begin
        if (count == 16'h0001) begin
          count     <= reload;
          outLevel  <= 1'b0;
          wrapPulse <= 1'b1;
        end else begin
          count    <= count - 16'h0001;
          outLevel <= 1'b1;
        end
      end
    end
  end

endmodule

/* File: test/dcir_host_model.sv */
/* Host bridge model: senses the active-low request as host software set it.
   Assumes the router's clock and reset. */
`timescale 1ns/10ps
module dcir_host_model (
  input  wire       ref_clk,
  input  wire       resetn,
  input  wire       hostIrqN,
  input  wire [1:0] senseSel,
  input  wire       edgeClear,
  output wire       irqActive
);
  reg lastN;
  reg latched;
  // ==========================================
  // sense: 0 low level, 1 high level, 2 falling, 3 rising
  always @(posedge ref_clk) begin
    if (!resetn) begin
      lastN <= 1'b1;
      latched <= 1'b0;
    end else begin
      lastN <= hostIrqN;
      if (edgeClear) begin
        latched <= 1'b0;
      end else if (senseSel[1] && hostIrqN != lastN && hostIrqN == senseSel[0]) begin
        latched <= 1'b1;
      end
    end
  end
  assign irqActive = senseSel[1] ? latched : (hostIrqN == senseSel[0]);
endmodule

/* File: test/dcir_router_asserts.sv */
/* Port checker for the interrupt router.
   Assumes it is bound to dcir_router; one clock domain. */
`timescale 1ns/10ps
module dcir_router_asserts (
  input wire        ref_clk,
  input wire        resetn,
  input wire [4:0]  ioAddr,
  input wire [7:0]  ioWrData,
  input wire        ioWrStb,
  input wire        ioRdStb,
  input wire [7:0]  ioRdData,
  input wire [95:0] pinOe,
  input wire        hostIrqN
);
  reg [2:0] ctl;
  reg [7:0] src;
  reg [7:0] lowCnt;
  // ==========================================
  // shadow of the two interrupt control bytes
  always @(posedge ref_clk) begin
    if (!resetn) begin
      ctl <= 3'h0;
      src <= 8'h00;
    end else if (ioWrStb && ioAddr == 5'h15) begin
      ctl <= ioWrData[2:0];
    end else if (ioWrStb && ioAddr == 5'h14) begin
      src <= ioWrData;
    end
  end
  always @(posedge ref_clk) begin
    lowCnt <= hostIrqN ? 8'h00 : lowCnt + 8'h01;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_master_off; !ctl[2] |=> hostIrqN; endproperty
  property p_ctr_off; !ctl[1] && src == 8'h00 |=> hostIrqN; endproperty
  property p_ctl_read;
    ioRdStb && ioAddr == 5'h15 |=> ioRdData == {5'h00, $past(ctl)};
  endproperty
  property p_src_read; ioRdStb && ioAddr == 5'h14 |=> ioRdData == $past(src); endproperty
  property p_unmapped; ioRdStb && ioAddr > 5'h15 |=> ioRdData == 8'h00; endproperty
  property p_rd_hold; !ioRdStb |=> $stable(ioRdData); endproperty
  property p_reset_in; $rose(resetn) |-> pinOe == 96'h0 && hostIrqN; endproperty
  property p_oe_write; !$past(ioWrStb, 2) && $past(resetn, 2) |-> $stable(pinOe); endproperty
  property p_tick_len;
    $rose(hostIrqN) && ctl == 3'b110 && src == 8'h00 |-> lowCnt == 8'd100;
  endproperty
  a_master_off: assert property (p_master_off) else $error("request with master off");
  a_ctr_off: assert property (p_ctr_off) else $error("request with no source");
  a_ctl_read: assert property (p_ctl_read) else $error("control readback wrong");
  a_src_read: assert property (p_src_read) else $error("enable readback wrong");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_reset_in: assert property (p_reset_in) else $error("pins driven after reset");
  a_oe_write: assert property (p_oe_write) else $error("direction moved unwritten");
  a_tick_len: assert property (p_tick_len) else $error("pulse not one tick");
  c_port_irq: cover property ($fell(hostIrqN) && src != 8'h00);
  c_ctr_sel1: cover property ($fell(hostIrqN) && ctl == 3'b111);
  c_unmapped: cover property (ioRdStb && ioAddr > 5'h15);
endmodule
bind dcir_router dcir_router_asserts i_dcir_router_asserts (
  .ref_clk(ref_clk), .resetn(resetn), .ioAddr(ioAddr), .ioWrData(ioWrData),
  .ioWrStb(ioWrStb), .ioRdStb(ioRdStb), .ioRdData(ioRdData), .pinOe(pinOe),
  .hostIrqN(hostIrqN));

/* File: test/testbench.sv */
/* Self-checking bench for the interrupt router.
   Assumes dcir_router, the host model and the bound checker. */
`timescale 1ns/10ps
module testbench;
  reg         ref_clk;
  reg         resetn;
  reg  [4:0]  ioAddr;
  reg  [7:0]  ioWrData;
  reg         ioWrStb;
  reg         ioRdStb;
  wire [7:0]  ioRdData;
  reg  [95:0] pinIn;
  wire [95:0] pinOut;
  wire [95:0] pinOe;
  wire        hostIrqN;
  reg  [1:0]  senseSel;
  reg         edgeClear;
  wire        irqActive;
  reg         rdPend = 1'b0;
  reg         lastN = 1'b1;
  integer     seed;
  integer     n_fail;
  integer     num_checks;
  integer     per = 0;
  integer     i;
  integer     g;
  logic [7:0] rdQ[$];
  int         perQ[$];
  dcir_router i_dcir_router (.ref_clk(ref_clk), .resetn(resetn), .ioAddr(ioAddr),
    .ioWrData(ioWrData), .ioWrStb(ioWrStb), .ioRdStb(ioRdStb), .ioRdData(ioRdData),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .hostIrqN(hostIrqN));
  dcir_host_model i_dcir_host_model (.ref_clk(ref_clk), .resetn(resetn),
    .hostIrqN(hostIrqN), .senseSel(senseSel), .edgeClear(edgeClear), .irqActive(irqActive));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task chk(input logic [95:0] seen, input logic [95:0] want);
    num_checks = num_checks + 1;
    if (seen !== want) begin
      n_fail = n_fail + 1;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    ioAddr = a;
    ioWrData = d;
    ioWrStb = 1'b1;
    @(negedge ref_clk);
    ioWrStb = 1'b0;
  endtask
  task rd(input logic [4:0] a, input logic [7:0] want);
    @(negedge ref_clk);
    ioAddr = a;
    ioRdStb = 1'b1;
    rdQ.push_back(want);
    @(negedge ref_clk);
    ioRdStb = 1'b0;
  endtask
  task quiet(input integer n);
    integer k;
    reg     low;
    low = 1'b0;
    for (k = 0; k < n; k++) begin
      @(negedge ref_clk);
      if (hostIrqN !== 1'b1) low = 1'b1;
    end
    chk(low, 1'b0);
  endtask
  // wait for a fall of the request, then expect two periods
  task periods(input integer p);
    integer k;
    k = 0;
    while (hostIrqN !== 1'b1 && k < 3000) begin @(negedge ref_clk); k++; end
    while (hostIrqN !== 1'b0 && k < 3000) begin @(negedge ref_clk); k++; end
    @(negedge ref_clk);
    perQ.push_back(p);
    perQ.push_back(p);
    while (perQ.size() > 0 && k < 3000) begin @(negedge ref_clk); k++; end
    if (k >= 3000) begin
      n_fail = n_fail + 1;
      test_done;
    end
  endtask
  // ==========================================
  // result monitor
  always @(posedge ref_clk) rdPend <= ioRdStb;
  always @(negedge ref_clk) begin
    if (rdPend && rdQ.size() > 0) chk(ioRdData, rdQ.pop_front());
    if (lastN === 1'b1 && hostIrqN === 1'b0) begin
      if (perQ.size() > 0) chk(per, perQ.pop_front());
      per = 0;
    end
    per = per + 1;
    lastN = hostIrqN;
  end
  // ==========================================
  // main sequence
  initial begin
    seed = 32'h74542282;
    {n_fail, num_checks} = 0;
    {resetn, ioAddr, ioWrData, ioWrStb, ioRdStb, pinIn, edgeClear} = 0;
    senseSel = 2'd2;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    resetn = 1'b1;
    chk(pinOe, 96'h0);
    rd(5'h15, 8'h00);
    for (g = 0; g < 4; g++) rd(5'(g * 4 + 3), 8'h9B);
    wr(5'h15, 8'hFF);
    rd(5'h15, 8'h07);
    wr(5'h15, 8'h00);
    i = $random(seed);
    wr(5'h14, i[7:0]);
    rd(5'h14, i[7:0]);
    for (g = 22; g < 32; g += 9) begin
      wr(5'(g), i[15:8]);
      rd(5'(g), 8'h00);
    end
    for (i = 0; i < 16; i++) begin
      g = i % 4;
      wr(5'(g * 4 + 3), {3'b100, i[3], i[2], 1'b0, i[1], i[0]});
      @(negedge ref_clk);
      chk(pinOe[g * 24 +: 24], {{4{~i[2]}}, {4{~i[0]}}, {8{~i[1]}}, {8{~i[3]}}});
    end
    for (i = 0; i < 8; i++) begin
      g = i / 2;
      wr(5'(g * 4 + 3), 8'hA0);
      pinIn = {$random(seed), $random(seed), $random(seed)};
      pinIn[g * 24 + 19] = ~i[0];
      pinIn[g * 24 + 16] = i[0];
      wr(5'h14, 8'h01 << (i ^ 1));
      wr(5'h15, 8'h04);
      quiet(3);
      wr(5'h14, 8'h01 << i);
      @(negedge ref_clk);
      chk(hostIrqN, 1'b0);
      wr(5'h15, 8'h00);
      @(negedge ref_clk);
      chk(hostIrqN, 1'b1);
    end
    wr(5'h14, 8'h00);
    i = $random(seed);
    wr(5'h0C, i[7:0]);
    rd(5'h0C, i[7:0]);
    chk(pinOut[72 +: 8], i[7:0]);
    // host loads low byte then high byte
    wr(5'h13, 8'h34);
    wr(5'h10, 8'h03);
    wr(5'h10, 8'h00);
    wr(5'h15, 8'h06);
    periods(300);
    chk(irqActive, 1'b1);
    edgeClear = 1'b1;
    @(negedge ref_clk);
    edgeClear = 1'b0;
    chk(irqActive, 1'b0);
    wr(5'h15, 8'h04);
    quiet(450);
    wr(5'h15, 8'h02);
    quiet(450);
    wr(5'h13, 8'h74);
    wr(5'h11, 8'h02);
    wr(5'h11, 8'h00);
    wr(5'h13, 8'h34);
    wr(5'h10, 8'h02);
    wr(5'h10, 8'h00);
    wr(5'h15, 8'h07);
    periods(400);
    senseSel = 2'd0;
    @(negedge ref_clk);
    chk(hostIrqN, 1'b0);
    chk(irqActive, 1'b1);
    resetn = 1'b0;
    repeat (3) @(negedge ref_clk);
    resetn = 1'b1;
    chk(pinOe, 96'h0);
    chk(hostIrqN, 1'b1);
    rd(5'h00, pinIn[7:0]);
    rd(5'h15, 8'h00);
    @(negedge ref_clk);
    test_done;
  end
endmodule
